// file: logic/ifc_pkg.sv
// Constants shared by the interrupt flag and control block.
// Assumes one 200 MHz clock and an AHB-Lite master with 32-bit data.
package ifc_pkg;

    localparam int REG_W = 16;
    localparam int IDX_W = 4;

    // Word index of each register (byte address is index times four).
    localparam logic [3:0] IDX_TRAP = 4'h0;
    localparam logic [3:0] IDX_VEC  = 4'h1;
    localparam logic [3:0] IDX_A    = 4'h2;
    localparam logic [3:0] IDX_B    = 4'h3;
    localparam logic [3:0] IDX_D    = 4'h4;
    localparam logic [3:0] IDX_E    = 4'h5;
    localparam logic [3:0] IDX_F    = 4'h6;
    localparam logic [3:0] IDX_STAT = 4'h7;
    localparam logic [3:0] IDX_MASK = 4'h8;

    // Implemented bits of the trap and flag registers.
    localparam logic [15:0] IMPL_TRAP = 16'h0006;
    localparam logic [15:0] IMPL_A    = 16'h3fef;
    localparam logic [15:0] IMPL_B    = 16'h201f;
    localparam logic [15:0] IMPL_D    = 16'h0200;
    localparam logic [15:0] IMPL_E    = 16'h0002;
    localparam logic [15:0] IMPL_F    = 16'hc000;

    // Flags absent on the smaller variant.
    localparam logic [15:0] SMALL_A = 16'h01c2;
    localparam logic [15:0] SMALL_B = 16'h0004;
    localparam logic [15:0] SMALL_F = 16'h8000;

    // Field positions.
    localparam int BIT_STK  = 2;
    localparam int BIT_OSC  = 1;
    localparam int BIT_ALT  = 15;
    localparam int BIT_HOLD = 14;
    localparam int BIT_EXT0 = 0;
    localparam int BIT_EXT1 = 4;
    localparam int BIT_EXT2 = 13;
    localparam logic [15:0] VEC_WMASK = 16'h8007;

    // Sticky status: one bit per trap or flag bank.
    localparam int NBANK = 6;
    localparam logic [15:0] RST_VAL = 16'h0000;

endpackage

// file: logic/ifc_reg_if.sv
// Register access strobes between the bus slave and the register file.
// Assumes a single clock domain; strobes are one-cycle pulses.
`timescale 1ns/1ps
interface ifc_reg_if;
    logic        wr_en;
    logic        rd_en;
    logic [3:0]  idx;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport bus  (output wr_en, output rd_en, output idx, output wdata, input rdata);
    modport regs (input wr_en, input rd_en, input idx, input wdata, output rdata);
endinterface

// file: logic/ifc_flag_reg.sv
// One request flag register with hardware set and software write.
// Assumes events are one-cycle pulses synchronous to mclk.
`timescale 1ns/1ps
module ifc_flag_reg
    import ifc_pkg::*;
#(
    parameter logic [15:0] IMPL = 16'h0000
) (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Software write and hardware set.
    input  wire logic        wr_en,
    input  wire logic [15:0] wdata,
    input  wire logic [15:0] evt,
    // Flag state.
    output logic [15:0]      q
);

    // A set in the same cycle as a software write of zero wins, so no
    // request is lost; absent bits never hold a one.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= RST_VAL;
        end else if (wr_en || (|(evt & IMPL))) begin
            q <= ((wr_en ? wdata : q) | evt) & IMPL; // R14 R16 R6
        end
    end

endmodule

// file: logic/ifc_top.sv
// Interrupt trap status, vector/edge control and request flag registers.
// Assumes an AHB-Lite master, synchronous event pulses and pins.
//
// Behaviour
// R1 - Stack error trap sets bit 2 of the trap register.
// R2 - Oscillator failure trap sets bit 1 of the trap register.
// R3 - Bit 15 of the control register selects the alternate vector table.
// R4 - Bit 14 of the control register shows the interrupt hold status.
// R5 - Bits 2..0 pick falling (1) or rising (0) edge per external input.
// R6 - Unimplemented bits ignore writes and read as zero.
// R7 - Flags A bits 13, 12, 11: ADC done, serial transmit, serial receive.
// R8 - Flags A bits 10, 9: SPI event and SPI fault.
// R9 - Flags A timers, compares, captures, external 0; bit 4 absent.
// R10 - Flags B: ext 2, ext 1, pin change, comparator, I2C master, slave.
// R11 - Flags D bit 9 holds the PWM special event match request.
// R12 - Flags E bit 1 holds the serial error request.
// R13 - Flags F bits 15, 14 hold PWM generator B and A requests.
// R14 - Flags read 1 after a request, are writable, reset to 0.
// R15 - Small variant leaves some flags absent, reading as zero.
// R16 - A flag holds until written 0; a same-cycle set wins.
`timescale 1ns/1ps
module ifc_top
    import ifc_pkg::*;
#(
    parameter logic SMALL = 1'b0
) (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rstn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Trap events and CPU status.
    input  wire logic        stack_fault_evt,
    input  wire logic        osc_loss_evt,
    input  wire logic        irq_hold_active,
    // Peripheral request pulses, laid out as the flag registers.
    input  wire logic [15:0] evt_a,
    input  wire logic [15:0] evt_b,
    input  wire logic [15:0] evt_d,
    input  wire logic [15:0] evt_e,
    input  wire logic [15:0] evt_f,
    // External interrupt pins.
    input  wire logic [2:0]  ext_pin,
    // Control outputs.
    output logic             alt_table_select,
    output logic [2:0]       ext_falling_select,
    output logic [15:0]      flags_a,
    output logic [15:0]      flags_b,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////
    // Bus slave.

    ifc_reg_if rif ();

    logic        ph_valid_q;
    logic        ph_write_q;
    logic        ph_map_q;
    logic [3:0]  ph_idx_q;
    logic        addr_ok;

    // Only aligned words inside the map are decoded; the rest answer OKAY
    // with zero data so a stray access cannot hang the bus.
    assign addr_ok = (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'h0)
                     && (haddr[5:2] <= IDX_MASK);

    // Capture the address phase.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_map_q   <= 1'b0;
            ph_idx_q   <= 4'h0;
        end else if (hready) begin
            ph_valid_q <= hsel && htrans[1];
            ph_write_q <= hwrite;
            ph_map_q   <= addr_ok;
            ph_idx_q   <= haddr[5:2];
        end
    end

    // Zero-wait slave; hsize is not checked because only words are used.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign rif.wr_en = ph_valid_q && ph_write_q && ph_map_q;
    assign rif.rd_en = ph_valid_q && !ph_write_q && ph_map_q;
    assign rif.idx   = ph_idx_q;
    assign rif.wdata = hwdata[15:0];
    assign hrdata    = {16'h0000, rif.rd_en ? rif.rdata : 16'h0000};

    ////////////////////////////////////////////////////////////////////
    // External pin edge detect.

    logic [15:0] vec_q;
    logic [2:0]  pin_q;
    logic [2:0]  ext_hit;

    // Previous pin level, for edge detection.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_q <= 3'h0;
        end else begin
            pin_q <= ext_pin;
        end
    end

    // A one in the polarity bit looks for a falling edge.
    assign ext_hit = (ext_falling_select & pin_q & ~ext_pin)
                     | (~ext_falling_select & ~pin_q & ext_pin); // R5

    ////////////////////////////////////////////////////////////////////
    // Vector table and edge control.

    // Writable bits only; the hold bit is never stored.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            vec_q <= RST_VAL;
        end else if (rif.wr_en && rif.idx == IDX_VEC) begin
            vec_q <= rif.wdata & VEC_WMASK; // R6
        end
    end

    assign alt_table_select   = vec_q[BIT_ALT]; // R3
    assign ext_falling_select = vec_q[2:0];

    ////////////////////////////////////////////////////////////////////
    // Trap and flag banks.

    logic [15:0] bank_q   [NBANK];
    logic [15:0] bank_evt [NBANK];
    logic [15:0] bank_imp [NBANK];
    logic [3:0]  bank_idx [NBANK];
    logic [15:0] ev_a;
    logic [15:0] ev_b;

    // External edges join the peripheral pulses.
    always_comb begin
        ev_a = evt_a;
        ev_b = evt_b;
        ev_a[BIT_EXT0] = evt_a[BIT_EXT0] | ext_hit[0];
        ev_b[BIT_EXT1] = evt_b[BIT_EXT1] | ext_hit[1];
        ev_b[BIT_EXT2] = evt_b[BIT_EXT2] | ext_hit[2];
    end

    // Bank wiring; the small variant drops absent flags.
    assign bank_evt[0] = {13'h0000, stack_fault_evt, osc_loss_evt, 1'b0}; // R1 R2
    assign bank_evt[1] = ev_a; // R7 R8 R9
    assign bank_evt[2] = ev_b; // R10
    assign bank_evt[3] = evt_d; // R11
    assign bank_evt[4] = evt_e; // R12
    assign bank_evt[5] = evt_f; // R13
    assign bank_imp[0] = IMPL_TRAP;
    assign bank_imp[1] = IMPL_A & ~(SMALL ? SMALL_A : 16'h0000); // R15
    assign bank_imp[2] = IMPL_B & ~(SMALL ? SMALL_B : 16'h0000);
    assign bank_imp[3] = IMPL_D;
    assign bank_imp[4] = IMPL_E;
    assign bank_imp[5] = IMPL_F & ~(SMALL ? SMALL_F : 16'h0000);
    assign bank_idx[0] = IDX_TRAP;
    assign bank_idx[1] = IDX_A;
    assign bank_idx[2] = IDX_B;
    assign bank_idx[3] = IDX_D;
    assign bank_idx[4] = IDX_E;
    assign bank_idx[5] = IDX_F;

    logic [NBANK-1:0] stat_set;

    // One flag register per bank.
    for (genvar g = 0; g < NBANK; g++) begin : g_bank
        logic [15:0] evm;
        assign evm         = bank_evt[g] & bank_imp[g];
        assign stat_set[g] = |evm;
        ifc_flag_reg #(
            .IMPL (16'hffff)
        ) u_flag (
            .mclk  (mclk),
            .rstn  (rstn),
            .wr_en (rif.wr_en && rif.idx == bank_idx[g] && 1'b1),
            .wdata (rif.wdata & bank_imp[g]),
            .evt   (evm),
            .q     (bank_q[g])
        );
    end

    assign flags_a = bank_q[1];
    assign flags_b = bank_q[2];

    ////////////////////////////////////////////////////////////////////
    // Interrupt status and mask.

    logic [NBANK-1:0] stat_q;
    logic [NBANK-1:0] mask_q;
    logic             stat_rd;

    assign stat_rd = rif.rd_en && rif.idx == IDX_STAT;

    // A read clears the status, but an event in that cycle survives.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_rd ? '0 : stat_q) | stat_set;
        end
    end

    // Mask register, software owned.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= '0;
        end else if (rif.wr_en && rif.idx == IDX_MASK) begin
            mask_q <= rif.wdata[NBANK-1:0];
        end
    end

    assign irq = |(stat_q & mask_q);

    ////////////////////////////////////////////////////////////////////
    // Read mux.

    // Unmapped positions in every register return zero.
    always_comb begin
        rif.rdata = 16'h0000;
        unique case (rif.idx)
            IDX_TRAP: rif.rdata = bank_q[0];
            IDX_VEC:  begin
                rif.rdata = vec_q;
                rif.rdata[BIT_HOLD] = irq_hold_active; // R4
            end
            IDX_A:    rif.rdata = bank_q[1];
            IDX_B:    rif.rdata = bank_q[2];
            IDX_D:    rif.rdata = bank_q[3];
            IDX_E:    rif.rdata = bank_q[4];
            IDX_F:    rif.rdata = bank_q[5];
            IDX_STAT: rif.rdata = {10'h000, stat_q};
            IDX_MASK: rif.rdata = {10'h000, mask_q};
            default:  rif.rdata = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    logic wr_a;
    assign wr_a = rif.wr_en && rif.idx == IDX_A;

    property p_stk;
        stack_fault_evt |=> bank_q[0][BIT_STK];
    endproperty
    a_stk: assert property (p_stk) else $error("stack flag not set"); // R1

    property p_osc;
        osc_loss_evt |=> bank_q[0][BIT_OSC];
    endproperty
    a_osc: assert property (p_osc) else $error("osc flag not set"); // R2

    property p_alt;
        (rif.wr_en && rif.idx == IDX_VEC) |=> alt_table_select == $past(hwdata[BIT_ALT]);
    endproperty
    a_alt: assert property (p_alt) else $error("table select wrong"); // R3

    property p_hold;
        (rif.rd_en && rif.idx == IDX_VEC) |-> hrdata[BIT_HOLD] == irq_hold_active;
    endproperty
    a_hold: assert property (p_hold) else $error("hold bit wrong"); // R4

    sequence s_fall0;
        ext_falling_select[0] && $fell(ext_pin[0]);
    endsequence
    property p_edge;
        s_fall0 ##1 1'b1 |-> flags_a[BIT_EXT0];
    endproperty
    a_edge: assert property (p_edge) else $error("falling edge missed"); // R5

    // The rising polarity is checked on a different input than the falling one.
    property p_rise;
        (!ext_falling_select[1] && $rose(ext_pin[1])) ##1 1'b1 |-> flags_b[BIT_EXT1];
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge missed"); // R5

    property p_unimpl;
        (rif.rd_en && rif.idx == IDX_VEC) |-> hrdata[13:3] == 11'h000;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("reserved bits set"); // R6

    // Registers are 16 bits wide, so the upper half of a read word is zero.
    property p_upper;
        rif.rd_en |-> hrdata[31:16] == 16'h0000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set"); // R6

    property p_bank_a;
        (evt_a[13] && evt_a[9]) |=> (flags_a[13] && flags_a[9] && !flags_a[4]);
    endproperty
    a_bank_a: assert property (p_bank_a) else $error("flag A not set"); // R7 R8 R9

    property p_bank_b;
        evt_b[3] |=> flags_b[3];
    endproperty
    a_bank_b: assert property (p_bank_b) else $error("flag B not set"); // R10

    property p_absent;
        (bank_q[3] & ~IMPL_D) == 16'h0000 && (bank_q[4] & ~IMPL_E) == 16'h0000
        && (bank_q[5] & ~IMPL_F) == 16'h0000;
    endproperty
    a_absent: assert property (p_absent) else $error("absent flag set"); // R11 R12 R13

    property p_small;
        SMALL |-> (flags_a & SMALL_A) == 16'h0000;
    endproperty
    a_small: assert property (p_small) else $error("variant flag set"); // R15

    property p_keep;
        (flags_a[12] && !wr_a) |=> flags_a[12];
    endproperty
    a_keep: assert property (p_keep) else $error("flag dropped"); // R14

    // A write of zero with no request pending empties the whole register.
    property p_clear;
        (wr_a && rif.wdata == 16'h0000 && evt_a == 16'h0000 && !ext_hit[0]) |=> flags_a == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared"); // R14

    property p_wins;
        (wr_a && !rif.wdata[13] && evt_a[13]) |=> flags_a[13];
    endproperty
    a_wins: assert property (p_wins) else $error("set lost to clear"); // R16

    // An unmasked event must reach the output through the sticky status.
    property p_irq;
        (|(stat_set & mask_q)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    // A status read with no event in the same cycle empties the status.
    property p_stat_clr;
        (stat_rd && stat_set == '0) |=> stat_q == '0;
    endproperty
    a_stat_clr: assert property (p_stat_clr) else $error("status not cleared");

endmodule

// file: testbench/ifc_src_model.sv
// Model of the on-chip requesters: peripheral, trap and external pin sources.
// Assumes the bench calls its tasks; every output moves just after a mclk edge.
`timescale 1ns/1ps
module ifc_src_model (
    // Clock.
    input  wire logic         mclk,
    // Request pulses, banks a, b, d, e, f, then trap (bit 2 stack, bit 1 osc).
    output logic [5:0][15:0]  evt,
    // External interrupt pins.
    output logic [2:0]        ext_pin
);
    ////////////////////////////////////////////////////////////////////////////
    // Quiet sources at time zero.
    initial begin
        evt     = '0;
        ext_pin = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-cycle request pulse; a held level would read as repeated requests.
    task automatic pulse(input int bank, input logic [15:0] mask);
        @(posedge mclk);
        evt[bank] <= mask;
        @(posedge mclk);
        evt[bank] <= '0;
    endtask

    // Pins change once and then rest, so both samples of the edge are seen.
    task automatic pin(input int n, input logic lvl);
        @(posedge mclk);
        ext_pin[n] <= lvl;
        repeat (3) @(posedge mclk);
    endtask
endmodule

// file: testbench/interrupt_flag_and_control_regs_tb.sv
// Self-checking bench for the interrupt flag and control registers.
// Assumes an AHB-Lite slave answering with hreadyout and a 200 MHz mclk.
`timescale 1ns/1ps
module interrupt_flag_and_control_regs_tb;
    import ifc_pkg::*;
    logic              mclk, rstn, hsel, hwrite, hold, hreadyout, hresp, alt, irq;
    logic [1:0]        htrans;
    logic [31:0]       haddr, hwdata, hrdata, hrdata_s, rd, rd_s;
    logic [2:0]        efs, ext_pin;
    logic [15:0]       fa, fb;
    logic [5:0][15:0]  evt;
    int                n_fail, n_checks;
    logic [3:0]        fidx [6] = '{IDX_TRAP, IDX_A, IDX_B, IDX_D, IDX_E, IDX_F};
    logic [15:0]       fimp [6] = '{IMPL_TRAP, IMPL_A, IMPL_B, IMPL_D, IMPL_E, IMPL_F};
    logic [15:0]       smal [6] = '{16'h0000, SMALL_A, SMALL_B, 16'h0000, 16'h0000, SMALL_F};
    int                eb [6]   = '{5, 0, 1, 2, 3, 4};
    int                epos [3] = '{0, 20, 29};

    ////////////////////////////////////////////////////////////////////////////
    // Full variant under test and small variant sharing its bus and sources.
    ifc_top u_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .stack_fault_evt(evt[5][2]), .osc_loss_evt(evt[5][1]),
        .irq_hold_active(hold), .evt_a(evt[0]), .evt_b(evt[1]), .evt_d(evt[2]), .evt_e(evt[3]),
        .evt_f(evt[4]), .ext_pin(ext_pin), .alt_table_select(alt), .ext_falling_select(efs),
        .flags_a(fa), .flags_b(fb), .irq(irq));
    ifc_top #(.SMALL(1'b1)) u_dut_small (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(), .hresp(), .hrdata(hrdata_s), .stack_fault_evt(evt[5][2]),
        .osc_loss_evt(evt[5][1]), .irq_hold_active(hold), .evt_a(evt[0]), .evt_b(evt[1]),
        .evt_d(evt[2]), .evt_e(evt[3]), .evt_f(evt[4]), .ext_pin(ext_pin), .alt_table_select(),
        .ext_falling_select(), .flags_a(), .flags_b(), .irq());
    ifc_src_model u_src (.mclk(mclk), .evt(evt), .ext_pin(ext_pin));

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 200 MHz.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Byte address of a register word.
    function automatic logic [31:0] ad(input logic [3:0] i);
        return {26'h0, i, 2'b00};
    endfunction

    // One single transfer; the wait on hreadyout stays open, the watchdog bounds it.
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        @(posedge mclk);
        hsel   <= 1'b1;
        haddr  <= addr;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd   = hrdata;
        rd_s = hrdata_s;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        stop_test();
    end

    // Main sequence.
    initial begin
        n_fail = 0;
        n_checks = 0;
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = '0;
        hold = 1'b0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i <= 9; i++) begin
            bus(1'b0, ad(4'(i)), 32'h0);
            chk(rd, 32'h0);
        end
        chk({hreadyout, hresp}, 32'h2);
        $display("test reset done");
        // Write ones, clear, then raise every request of the bank.
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, ad(fidx[i]), 32'hffff_ffff);
            bus(1'b0, ad(fidx[i]), 32'h0);
            chk(rd, {16'h0, fimp[i]});
            chk(rd_s, {16'h0, fimp[i] & ~smal[i]});
            bus(1'b1, ad(fidx[i]), 32'h0);
            bus(1'b0, ad(fidx[i]), 32'h0);
            chk(rd, 32'h0);
            u_src.pulse(eb[i], 16'hffff);
            bus(1'b0, ad(fidx[i]), 32'h0);
            chk(rd, {16'h0, fimp[i]});
            chk(rd_s, {16'h0, fimp[i] & ~smal[i]});
            bus(1'b0, ad(fidx[i]), 32'h0);
            chk(rd, {16'h0, fimp[i]});
            bus(1'b1, ad(fidx[i]), 32'h0);
        end
        u_src.pulse(5, 16'h0004);
        bus(1'b0, ad(IDX_TRAP), 32'h0);
        chk(rd, 32'h4);
        u_src.pulse(5, 16'h0002);
        bus(1'b0, ad(IDX_TRAP), 32'h0);
        chk(rd, 32'h6);
        bus(1'b1, ad(IDX_TRAP), 32'h0);
        // Unmapped words, two (0x48 and 0x0a) aliasing flags A in their low index bits.
        bus(1'b1, 32'h24, 32'hffff_ffff);
        bus(1'b1, 32'h48, 32'hffff_ffff);
        bus(1'b1, 32'h0a, 32'hffff_ffff);
        bus(1'b0, 32'h24, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, ad(IDX_A), 32'h0);
        chk(rd, 32'h0);
        $display("test flags done");
        // Control word: hold status is read-only, bits 13 to 3 are absent.
        hold <= 1'b1;
        bus(1'b1, ad(IDX_VEC), 32'hffff_ffff);
        bus(1'b0, ad(IDX_VEC), 32'h0);
        chk(rd, 32'hc007);
        chk({alt, efs}, 32'hf);
        hold <= 1'b0;
        bus(1'b1, ad(IDX_VEC), 32'h4002);
        bus(1'b0, ad(IDX_VEC), 32'h0);
        chk(rd, 32'h2);
        chk({alt, efs}, 32'h2);
        $display("test control done");
        // A request at the edge that commits a software clear must survive it.
        u_src.pulse(0, 16'h1000);
        fork
            bus(1'b1, ad(IDX_A), 32'h0);
            begin
                @(posedge mclk);
                u_src.pulse(0, 16'h2000);
            end
        join
        #1;
        chk(fa, 32'h2000);
        bus(1'b1, ad(IDX_A), 32'h0);
        $display("test set priority done");
        // Interrupt: every bank has fired, nothing is unmasked yet.
        bus(1'b0, ad(IDX_STAT), 32'h0);
        chk(rd, 32'h3f);
        chk(irq, 32'h0);
        bus(1'b1, ad(IDX_MASK), 32'hffc2);
        bus(1'b0, ad(IDX_MASK), 32'h0);
        chk(rd, 32'h2);
        u_src.pulse(1, 16'h0008);
        #1;
        chk(irq, 32'h0);
        u_src.pulse(0, 16'h0800);
        #1;
        chk(irq, 32'h1);
        bus(1'b0, ad(IDX_STAT), 32'h0);
        #1;
        chk(rd, 32'h6);
        chk(irq, 32'h0);
        $display("test interrupt done");
        // External pins: the wrong edge must not set, the selected one must.
        for (int n = 0; n < 3; n++) begin
            for (int p = 0; p < 2; p++) begin
                bus(1'b1, ad(IDX_VEC), p ? 32'h7 : 32'h0);
                u_src.pin(n, !p);
                bus(1'b1, ad(IDX_A), 32'h0);
                bus(1'b1, ad(IDX_B), 32'h0);
                u_src.pin(n, p);
                #1;
                chk({fb, fa}, 32'h0);
                u_src.pin(n, !p);
                #1;
                chk({fb, fa}, 32'h1 << epos[n]);
            end
        end
        $display("test pins done");
        stop_test();
    end
endmodule
